// >>> logic/dhps_defs.svh
// constants of the host port sequencer: selects, phase counts, reset values
`ifndef DHPS_DEFS_SVH
`define DHPS_DEFS_SVH

`define DHPS_SEL_CONTROL 2'h0
`define DHPS_SEL_DATA_INC 2'h2
`define DHPS_SEL_DATA_NOINC 2'h3
`define DHPS_BE_ALL_ACTIVE 4'h0
`define DHPS_LANES_OFF 2'h3
`define DHPS_LAST_PHASE_PAIR 2'h1
`define DHPS_LAST_PHASE_QUAD 2'h3
`define DHPS_FIFO_DEPTH 32
`define DHPS_REQ_WIDTH 40
// idle pins: selects high, read, both targets off, strobe high, lanes off, bus released
`define DHPS_PINS_RESET 26'h3f7_0000
`define DHPS_RDATA_RESET 32'h0000_0000

`endif

// >>> logic/dhps_pkg.sv
// types shared by the host port sequencer, its checks, its target model and its bench
package dhps_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RELEASE,
    ST_DONE
  } dhps_state_type;

  typedef struct packed {
    logic isWrite;
    logic targetTwo;
    logic [1:0] accessSel;
    logic [3:0] byteEnN;
    logic [31:0] data;
  } dhps_req_type;

  typedef struct packed {
    logic accessSelectHi;
    logic accessSelectLo;
    logic readNotWrite;
    logic targetSelectOneN;
    logic targetSelectTwoN;
    logic transferStrobeN;
    logic halfWordMarker;
    logic laneEnableHighN;
    logic laneEnableLowN;
    logic portDataOeN;
    logic [15:0] portDataOut;
  } dhps_pins_type;

  typedef struct packed {
    logic isWrite;
    logic laneError;
    logic [31:0] data;
  } dhps_rsp_type;

  typedef struct packed {
    dhps_state_type state;
    logic [1:0] phase;
    logic [1:0] lastPhase;
    logic wide;
    logic wordOrder;
    logic [3:0] lanesN;
    dhps_req_type req;
    logic [31:0] rdData;
    dhps_pins_type pins;
    logic rspValid;
    dhps_rsp_type rsp;
  } dhps_seq_state_type;

endpackage : dhps_pkg

// >>> logic/dhps_fifo.sv
// request queue with registered ready and occupancy count
`timescale 1ns/100ps
`include "dhps_defs.svh"

module dhps_fifo #(
  parameter int WIDTH = `DHPS_REQ_WIDTH,
  parameter int DEPTH = `DHPS_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  // depth must be a power of two so the pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
    logic inReady;
  } dhps_fifo_state_type;

  dhps_fifo_state_type s_q;
  dhps_fifo_state_type s_d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push;
  logic pop;

  assign push = inValid && s_q.inReady;
  assign pop = outValid && outReady;
  assign inReady = s_q.inReady;
  assign outValid = (s_q.count != '0);
  assign outData = mem[s_q.rdPtr];

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wrPtr = s_q.wrPtr + 1'b1;
    end
    if (pop) begin
      s_d.rdPtr = s_q.rdPtr + 1'b1;
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
    s_d.inReady = (s_d.count < (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '{wrPtr: '0, rdPtr: '0, count: '0, inReady: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wrPtr] <= inData;
    end
  end

endmodule : dhps_fifo

// >>> logic/dhps_sequencer.sv
// host port sequencer: system requests to byte or half-word serial port phases
//
// How it works
// - every transaction starts from idle pins: targets and strobe deasserted
// - data register access without increment drives both selects high before strobe
// - read/write line high for reads, low for writes, set in setup phase
// - strobe asserts with target select one clock after the setup clock
// - strobe and marker held until target ready is seen; wait cycles inserted
// - read phase: on ready, strobe and marker go high, low data lines captured
// - after last read byte target deselected, data returned least significant first
// - target latches write data at strobe rise; marker raised after first byte
// - narrow doubleword to non-increment address: four phases, increment select from second
// - wide flavour has a single operating mode, no shared or host-only mode
// - wide flavour: exactly two consecutive half-word phases per 32-bit word
// - marker tells first from second half; word order picks which half first
// - full-word half sequence never interrupted once started
// - low lane enable governs low byte of half, high lane enable high byte
// - only single byte, single half or full word lane patterns are driven
// - wide flavour wait comes from ready pin or ready status bit
// - word order bit clear puts most significant part first, set least first
// - wide select 10 is data with increment, 11 data without increment
`timescale 1ns/100ps
`include "dhps_defs.svh"

module dhps_sequencer #(
  parameter int FIFO_DEPTH = `DHPS_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic reqValid,
  output logic reqReady,
  input wire dhps_pkg::dhps_req_type req,
  input wire logic wideFlavour,
  input wire logic wordOrderBit,
  input wire logic targetWaitLine,
  input wire logic targetWaitIndicator,
  input wire logic [15:0] portDataIn,
  output dhps_pkg::dhps_pins_type portPins,
  output logic rspValid,
  output dhps_pkg::dhps_rsp_type rsp
);
  import dhps_pkg::*;

  //----------------------------------------------------------------
  // reset release
  //----------------------------------------------------------------
  logic rstnMeta_q;
  logic rstnSync_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rstnMeta_q <= 1'b0;
      rstnSync_q <= 1'b0;
    end else begin
      rstnMeta_q <= 1'b1;
      rstnSync_q <= rstnMeta_q;
    end
  end

  //----------------------------------------------------------------
  // request queue
  //----------------------------------------------------------------
  logic fifoValid;
  logic fifoPop;
  dhps_req_type fifoData;

  dhps_fifo #(
    .WIDTH($bits(dhps_req_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(ref_clk),
    .rstN(rstnSync_q),
    .inValid(reqValid),
    .inReady(reqReady),
    .inData(req),
    .outValid(fifoValid),
    .outReady(fifoPop),
    .outData(fifoData)
  );

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------
  // a pattern outside the three legal shapes is refused as a whole, so no
  // stray byte of a half-written word lands in target memory
  function automatic logic laneLegal(input logic [3:0] beN);
    logic [2:0] active;
    active = 3'(!beN[0]) + 3'(!beN[1]) + 3'(!beN[2]) + 3'(!beN[3]);
    laneLegal = (beN == `DHPS_BE_ALL_ACTIVE) || (active == 3'h1) ||
                (beN == 4'h3) || (beN == 4'hc);
  endfunction : laneLegal

  // bit offset of the byte or half carried by a phase
  function automatic logic [4:0] laneOffset(input logic wide, input logic wob,
                                            input logic [1:0] ph);
    if (wide) begin
      laneOffset = {ph[0] ^ ~wob, 4'h0};
    end else begin
      laneOffset = {ph, 3'h0};
    end
  endfunction : laneOffset

  // pins of a phase whose strobe opens at the next edge
  function automatic dhps_pins_type phasePins(input dhps_pins_type p,
                                              input dhps_seq_state_type s,
                                              input logic [1:0] ph);
    logic [4:0] off;
    dhps_pins_type n;
    off = laneOffset(s.wide, s.wordOrder, ph);
    n = p;
    n.transferStrobeN = 1'b0;
    n.halfWordMarker = ph[0];
    n.portDataOeN = !s.req.isWrite;
    if (s.wide) begin
      n.portDataOut = s.req.data[off +: 16];
    end else begin
      n.portDataOut = {8'h00, s.req.data[off +: 8]};
    end
    n.laneEnableHighN = 1'b1;
    n.laneEnableLowN = 1'b1;
    if (s.wide && s.req.isWrite && s.req.accessSel[1]) begin
      n.laneEnableHighN = s.lanesN[off[4:3] + 2'h1];
      n.laneEnableLowN = s.lanesN[off[4:3]];
    end
    phasePins = n;
  endfunction : phasePins

  // pins of the setup clock: selects and direction lead the strobe by one clock
  function automatic dhps_pins_type setupPins(input dhps_pins_type p,
                                              input dhps_req_type r);
    dhps_pins_type n;
    n = p;
    n.accessSelectHi = r.accessSel[1];
    n.accessSelectLo = r.accessSel[0];
    n.readNotWrite = !r.isWrite;
    setupPins = n;
  endfunction : setupPins

  // exactly one target select goes low and stays low until the last release
  function automatic dhps_pins_type selectTarget(input dhps_pins_type p, input logic two);
    dhps_pins_type n;
    n = p;
    n.targetSelectOneN = two;
    n.targetSelectTwoN = !two;
    selectTarget = n;
  endfunction : selectTarget

  // wide flavour waits on both sources; either can hold the phase open
  function automatic logic readySeen(input logic wide, input logic pin, input logic bitReady);
    if (wide) begin
      readySeen = pin && bitReady;
    end else begin
      readySeen = pin;
    end
  endfunction : readySeen

  // a narrow port moves four bytes only when every byte of the word is enabled
  function automatic logic [1:0] lastPhaseOf(input logic wide, input logic [3:0] beN);
    if (!wide && (beN == `DHPS_BE_ALL_ACTIVE)) begin
      lastPhaseOf = `DHPS_LAST_PHASE_QUAD;
    end else begin
      lastPhaseOf = `DHPS_LAST_PHASE_PAIR;
    end
  endfunction : lastPhaseOf

  // only data writes on the wide port are held to the legal lane shapes
  function automatic logic laneFault(input logic wide, input dhps_req_type r);
    logic dataWrite;
    dataWrite = wide && r.isWrite && r.accessSel[1];
    laneFault = dataWrite && !laneLegal(r.byteEnN);
  endfunction : laneFault

  // the upper half of a narrow doubleword to the fixed data address must land
  // one location up, so the pointer is bumped through the incrementing select
  function automatic logic incSwitch(input dhps_seq_state_type s);
    incSwitch = (s.phase == 2'h0) && (s.lastPhase == `DHPS_LAST_PHASE_QUAD) &&
                (s.req.accessSel == `DHPS_SEL_DATA_NOINC);
  endfunction : incSwitch

  // read data lands at the bit position the phase would have driven
  function automatic logic [31:0] captureRead(input logic [31:0] acc, input logic wide,
                                              input logic [4:0] off, input logic [15:0] bus);
    logic [31:0] r;
    r = acc;
    if (wide) begin
      r[off +: 16] = bus;
    end else begin
      r[off +: 8] = bus[7:0];
    end
    captureRead = r;
  endfunction : captureRead

  //----------------------------------------------------------------
  // sequencer
  //----------------------------------------------------------------
  dhps_seq_state_type s_q;
  dhps_seq_state_type s_d;
  logic targetReady;
  logic [4:0] capOff;

  assign targetReady = readySeen(s_q.wide, targetWaitLine, targetWaitIndicator);
  assign capOff = laneOffset(s_q.wide, s_q.wordOrder, s_q.phase);
  assign fifoPop = (s_q.state == ST_IDLE);

  //----------------------------------------------------------------
  // outputs: straight from the state register
  //----------------------------------------------------------------
  assign portPins = s_q.pins;
  assign rspValid = s_q.rspValid;
  assign rsp = s_q.rsp;

  always_comb begin
    s_d = s_q;
    s_d.rspValid = 1'b0;
    case (s_q.state)
      ST_IDLE: begin
        // pins already idle here: done state restored them
        if (fifoValid) begin
          s_d.req = fifoData;
          s_d.wide = wideFlavour;
          s_d.wordOrder = wordOrderBit;
          s_d.phase = 2'h0;
          s_d.rdData = `DHPS_RDATA_RESET;
          s_d.lanesN = fifoData.byteEnN;
          if (laneFault(wideFlavour, fifoData)) begin
            s_d.lanesN = 4'hf;
          end
          s_d.lastPhase = lastPhaseOf(wideFlavour, fifoData.byteEnN);
          s_d.pins = setupPins(s_q.pins, fifoData);
          s_d.state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        s_d.pins = selectTarget(phasePins(s_q.pins, s_q, 2'h0), s_q.req.targetTwo);
        s_d.state = ST_STROBE;
      end
      ST_STROBE: begin
        if (targetReady) begin
          s_d.pins.transferStrobeN = 1'b1;
          s_d.pins.halfWordMarker = 1'b1;
          if (!s_q.req.isWrite) begin
            s_d.rdData = captureRead(s_q.rdData, s_q.wide, capOff, portDataIn);
          end
          if (incSwitch(s_q)) begin
            s_d.pins.accessSelectHi = 1'b0;
          end
          if (s_q.phase == s_q.lastPhase) begin
            s_d.pins.targetSelectOneN = 1'b1;
            s_d.pins.targetSelectTwoN = 1'b1;
            s_d.state = ST_DONE;
          end else begin
            s_d.state = ST_RELEASE;
          end
        end
      end
      ST_RELEASE: begin
        // write data held through this cycle: the target latches on the rise
        s_d.phase = s_q.phase + 2'h1;
        s_d.pins = phasePins(s_q.pins, s_q, s_q.phase + 2'h1);
        s_d.state = ST_STROBE;
      end
      ST_DONE: begin
        s_d.pins = `DHPS_PINS_RESET;
        s_d.rspValid = 1'b1;
        s_d.rsp.isWrite = s_q.req.isWrite;
        // flag formed here so the last response stays whole until the next one
        s_d.rsp.laneError = laneFault(s_q.wide, s_q.req);
        s_d.rsp.data = s_q.rdData;
        s_d.state = ST_IDLE;
      end
      default: begin
        s_d.pins = `DHPS_PINS_RESET;
        s_d.state = ST_IDLE;
      end
    endcase
  end

  //----------------------------------------------------------------
  // state register
  //----------------------------------------------------------------
  // reset image: idle pins, nothing pending, empty read buffer
  localparam dhps_seq_state_type SEQ_RESET = '{
    state: ST_IDLE,
    phase: 2'h0,
    lastPhase: 2'h0,
    wide: 1'b0,
    wordOrder: 1'b0,
    lanesN: 4'h0,
    req: '0,
    rdData: `DHPS_RDATA_RESET,
    pins: `DHPS_PINS_RESET,
    rspValid: 1'b0,
    rsp: '0
  };

  always_ff @(posedge ref_clk or negedge rstnSync_q) begin
    if (!rstnSync_q) begin
      s_q <= SEQ_RESET;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : dhps_sequencer

// >>> dv/dhps_sequencer_properties.sv
// concurrent checks on the host port sequencer ports
`timescale 1ns/100ps
module dhps_sequencer_properties
  import dhps_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic wideFlavour,
  input wire logic targetWaitLine,
  input wire logic targetWaitIndicator,
  input wire dhps_pkg::dhps_pins_type portPins,
  input wire logic rspValid
);
  // ----
  // release counting per transaction
  // ----
  logic [2:0] relCnt_q;
  logic strobeN_q;
  logic rdy;
  logic idle;
  assign rdy = targetWaitLine && (targetWaitIndicator || !wideFlavour);
  assign idle = portPins.targetSelectOneN && portPins.targetSelectTwoN;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      relCnt_q <= 3'h0;
      strobeN_q <= 1'b1;
    end else begin
      strobeN_q <= portPins.transferStrobeN;
      if (!strobeN_q && portPins.transferStrobeN) begin
        relCnt_q <= relCnt_q + 3'h1;
      end else if (rspValid) begin
        relCnt_q <= 3'h0;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence sStart;
    $fell(portPins.targetSelectOneN) || $fell(portPins.targetSelectTwoN);
  endsequence
  sequence sRelease;
    $rose(portPins.transferStrobeN) && portPins.halfWordMarker;
  endsequence
  a_idle_at_end: assert property (rspValid |-> idle && portPins.transferStrobeN)
    else $error("target selected at response");
  a_one_target: assert property (!portPins.transferStrobeN |-> !idle &&
    portPins.targetSelectOneN != portPins.targetSelectTwoN)
    else $error("strobe without single target");
  a_first_open: assert property (sStart |-> $fell(portPins.transferStrobeN) &&
    !portPins.halfWordMarker)
    else $error("bad first strobe");
  a_wait_hold: assert property (!portPins.transferStrobeN && !rdy |=>
    !portPins.transferStrobeN && $stable(portPins.halfWordMarker))
    else $error("strobe released while waiting");
  a_release_step: assert property (!portPins.transferStrobeN && rdy |=> sRelease)
    else $error("no release after ready");
  a_select_span: assert property ($rose(portPins.targetSelectOneN) ||
    $rose(portPins.targetSelectTwoN) |-> $rose(portPins.transferStrobeN) ##1 rspValid)
    else $error("target deselected early");
  a_phase_count: assert property (rspValid |-> (wideFlavour ? relCnt_q == 3'h2 :
    (relCnt_q == 3'h2 || relCnt_q == 3'h4)))
    else $error("wrong phase count");
  a_capture_stable: assert property (!portPins.transferStrobeN |->
    $stable(portPins.readNotWrite) && $stable(portPins.accessSelectHi) &&
    portPins.portDataOeN == portPins.readNotWrite)
    else $error("controls moved at strobe");
  a_inc_switch: assert property ($fell(portPins.accessSelectHi) && !idle |->
    $rose(portPins.transferStrobeN) && relCnt_q == 3'h0 && !wideFlavour)
    else $error("bad increment switch");
  a_read_lanes: assert property (!portPins.transferStrobeN && portPins.readNotWrite |->
    portPins.laneEnableHighN && portPins.laneEnableLowN)
    else $error("lanes driven on read");
endmodule : dhps_sequencer_properties

bind dhps_sequencer dhps_sequencer_properties #(.FIFO_DEPTH(FIFO_DEPTH)) uProps (
  .ref_clk(ref_clk), .rstn(rstn), .wideFlavour(wideFlavour), .targetWaitLine(targetWaitLine),
  .targetWaitIndicator(targetWaitIndicator), .portPins(portPins), .rspValid(rspValid));

// >>> dv/dhps_target_model.sv
// behavioural target on the far side of the host port
`timescale 1ns/100ps
module dhps_target_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire logic wob,
  input wire logic wide,
  input wire dhps_pkg::dhps_pins_type pins,
  input wire logic [31:0] rdWord,
  output logic waitLine = 1'b1,
  output logic waitInd = 1'b1,
  output logic [15:0] dataOut,
  output logic [31:0] wrWord = 32'h0000_0000,
  output logic [2:0] incCnt = 3'h0
);
  import dhps_pkg::*;
  logic [1:0] k = 2'h0;
  logic [1:0] cnt = 2'h0;
  logic [15:0] last_q = 16'h0000;
  logic [31:0] w;
  logic sel, rdy, inc, go;
  logic [4:0] pos;
  assign sel = !(pins.targetSelectOneN && pins.targetSelectTwoN);
  assign rdy = waitLine && (waitInd || !wide);
  assign inc = wide ? pins.accessSelectHi && !pins.accessSelectLo :
    !pins.accessSelectHi && pins.accessSelectLo;
  assign pos = wide ? ((k[0] ^ !wob) ? 5'h10 : 5'h00) : {k, 3'h0};
  assign go = sel && !pins.transferStrobeN && rdy;
  // released lines toggle so stale data cannot pass for a read
  assign dataOut = (sel && !pins.transferStrobeN) ?
    (wide ? 16'(rdWord >> pos) : {8'ha5, 8'(rdWord >> pos)}) : ~last_q;
  always @(posedge ref_clk) begin
    last_q <= dataOut;
    cnt <= pins.transferStrobeN ? 2'h0 : cnt + {1'b0, cnt != 2'h3};
    waitLine <= !slow || (!pins.transferStrobeN && cnt >= 2'h1);
    waitInd <= !slow || (!pins.transferStrobeN && cnt >= 2'h2);
    w = (k == 2'h0) ? 32'h0000_0000 : wrWord;
    if (go) begin
      k <= k + 2'h1;
      incCnt <= ((k == 2'h0) ? 3'h0 : incCnt) + {2'h0, inc};
      if (!pins.readNotWrite) begin
        if (!wide || !pins.laneEnableLowN || !pins.accessSelectHi) begin
          w[pos +: 8] = pins.portDataOut[7:0];
        end
        if (wide && (!pins.laneEnableHighN || !pins.accessSelectHi)) begin
          w[pos + 8 +: 8] = pins.portDataOut[15:8];
        end
        wrWord <= w;
      end
    end
    if (!sel) k <= 2'h0;
  end
endmodule : dhps_target_model

// >>> dv/dhps_sequencer_tb.sv
// self-checking bench of the host port sequencer with a target model
`timescale 1ns/100ps
module dhps_sequencer_tb;
  import dhps_pkg::*;
  typedef struct packed {
    dhps_rsp_type rsp;
    logic [31:0] wr;
    logic [2:0] inc;
  } dhps_note_type;
  logic ref_clk, rstn, reqValid, reqReady, wideFlavour, wordOrderBit;
  logic slow, waitLine, waitInd, rspValid, sawFull;
  logic [15:0] dataIn;
  logic [31:0] rdWord, wrWord, lfsr;
  logic [2:0] incCnt;
  logic [3:0] beTab [8] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'ha};
  dhps_req_type req;
  dhps_pins_type portPins;
  dhps_rsp_type rsp;
  dhps_note_type notes[$];
  dhps_note_type n;
  int err_count, cmp_count, cyc;
  dhps_sequencer #(.FIFO_DEPTH(32)) dut (.ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .wideFlavour(wideFlavour), .wordOrderBit(wordOrderBit),
    .targetWaitLine(waitLine), .targetWaitIndicator(waitInd), .portDataIn(dataIn),
    .portPins(portPins), .rspValid(rspValid), .rsp(rsp));
  dhps_target_model mdl (.ref_clk(ref_clk), .slow(slow), .wob(wordOrderBit),
    .wide(wideFlavour), .pins(portPins), .rdWord(rdWord), .waitLine(waitLine),
    .waitInd(waitInd), .dataOut(dataIn), .wrWord(wrWord), .incCnt(incCnt));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize;
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : summarize
  // ----
  // request driver, notes the expected outcome when taken
  // ----
  task automatic send(input logic w, input logic [1:0] sel, input logic [3:0] be);
    logic quad, dw, legal;
    logic [31:0] m;
    dhps_note_type e;
    lfsr = nextRand(lfsr);
    quad = !wideFlavour && be == 4'h0;
    dw = wideFlavour && w && sel[1];
    legal = !dw || be inside {4'he, 4'hd, 4'hb, 4'h7, 4'hc, 4'h3, 4'h0};
    m = (quad || wideFlavour) ? 32'hffff_ffff : 32'h0000_ffff;
    if (dw) m = {{8{!be[3]}}, {8{!be[2]}}, {8{!be[1]}}, {8{!be[0]}}} & {32{legal}};
    e.rsp = {w, !legal, rdWord & m};
    e.wr = lfsr & m;
    e.inc = wideFlavour ? (sel == 2'h2 ? 3'h2 : 3'h0) :
      sel == 2'h1 ? (quad ? 3'h4 : 3'h2) : (sel == 2'h3 && quad ? 3'h3 : 3'h0);
    req = {w, lfsr[8], sel, be, lfsr};
    reqValid = 1'b1;
    while (!reqReady) begin
      sawFull = 1'b1;
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    notes.push_back(e);
    #1;
  endtask : send
  always @(posedge ref_clk) begin
    #2;
    if (rspValid === 1'b1) begin
      if (notes.size() == 0) begin
        check("extra response", 32'h1, 32'h0);
      end else begin
        n = notes.pop_front();
        check("isWrite", rsp.isWrite, n.rsp.isWrite);
        check("laneError", rsp.laneError, n.rsp.laneError);
        if (n.rsp.isWrite) check("written", wrWord, n.wr);
        else check("read data", rsp.data, n.rsp.data);
        check("increments", incCnt, n.inc);
      end
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {rstn, reqValid, wideFlavour, wordOrderBit, slow, sawFull} = 6'h00;
    req = '0;
    lfsr = 32'h6b0a_af18;
    rdWord = 32'h0000_0000;
    {err_count, cmp_count, cyc} = '0;
    repeat (6) @(posedge ref_clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    for (int f = 0; f < 4; f++) begin
      {wideFlavour, wordOrderBit} = f[1:0];
      rdWord = lfsr;
      for (int i = 0; i < 48; i++) begin
        slow = lfsr[3];
        send(lfsr[5], lfsr[7:6], beTab[lfsr[11:9]]);
      end
      reqValid = 1'b0;
      for (int i = 0; i < 4000 && notes.size() > 0; i++) @(posedge ref_clk);
      #1;
    end
    check("queue refused", sawFull, 32'h1);
    check("pending responses", notes.size(), 32'h0);
    summarize();
  end
endmodule : dhps_sequencer_tb
